// file: pkg/src_mon_pkg.sv
// Constants, types and timing figures for the source threshold monitor
`default_nettype none
package src_mon_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int V_W = 10;
  localparam int F_W = 13;
  localparam int PCT_W = 5;
  localparam int MATH_W = 24;
  localparam int CNT_W = 16;
  localparam int NCOND = 4;
  // ----------------------------------------
  // Delta dropout settings, in percent of rated
  // ----------------------------------------
  localparam logic [PCT_W-1:0] V_PCT_DEF = 5'h0A;
  localparam logic [PCT_W-1:0] V_PCT_MIN = 5'h04;
  localparam logic [PCT_W-1:0] V_PCT_MAX = 5'h14;
  localparam logic [PCT_W-1:0] F_PCT_DEF = 5'h05;
  localparam logic [PCT_W-1:0] F_PCT_MIN = 5'h02;
  localparam logic [PCT_W-1:0] F_PCT_MAX = 5'h0A;
  // Hysteresis is delta / HYST_DIV; compare scale is percent * divisor
  localparam int PCT_FULL = 100;
  localparam int HYST_DIV = 5;
  localparam int SCALE = PCT_FULL * HYST_DIV;
  // ----------------------------------------
  // Rated values selected by DIP switch (volts, 0.01 Hz units)
  // ----------------------------------------
  localparam logic [V_W-1:0] RATED_V0 = 10'h0DC;
  localparam logic [V_W-1:0] RATED_V1 = 10'h0E6;
  localparam logic [V_W-1:0] RATED_V2 = 10'h0F0;
  localparam logic [V_W-1:0] RATED_V3 = 10'h190;
  localparam logic [F_W-1:0] RATED_F50 = 13'h1388;
  localparam logic [F_W-1:0] RATED_F60 = 13'h1770;
  // ----------------------------------------
  // Condition bit positions
  // ----------------------------------------
  localparam int C_OV = 0;
  localparam int C_UV = 1;
  localparam int C_OF = 2;
  localparam int C_UF = 3;
  // ----------------------------------------
  // Timing: delay settings count 1 ms ticks
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  typedef enum logic {ST_OPEN, ST_CLOSED} sw_state_e;
endpackage
`default_nettype wire

// file: pkg/src_flags_if.sv
// Per-source bundle between the top, the limit checker and the qualifier
`timescale 1ns/1ps
`default_nettype none
interface src_flags_if;
  import src_mon_pkg::*;
  logic [V_W-1:0] meas_v;
  logic [V_W-1:0] rated_v;
  logic [F_W-1:0] meas_f;
  logic [F_W-1:0] rated_f;
  logic [PCT_W-1:0] v_pct;
  logic [PCT_W-1:0] f_pct;
  logic [NCOND-1:0] beyond;
  logic [NCOND-1:0] back_in;
  logic [NCOND-1:0] fault;
  logic tick;
  logic [CNT_W-1:0] delay;
  modport top (output meas_v, rated_v, meas_f, rated_f, v_pct, f_pct, tick, delay,
               input fault);
  modport chk (input meas_v, rated_v, meas_f, rated_f, v_pct, f_pct,
               output beyond, back_in);
  modport qual (input beyond, back_in, tick, delay, output fault);
endinterface
`default_nettype wire

// file: rtl/limit_checker.sv
// Dropout and pickup comparison for one source, voltage and frequency
`timescale 1ns/1ps
`default_nettype none
module limit_checker (
  src_flags_if.chk flags
);
  import src_mon_pkg::*;
  // ----------------------------------------
  // Compare in units of rated / SCALE to stay exact
  // ----------------------------------------
  // Returns {uv_back, ov_back, uv_beyond, ov_beyond}
  function automatic logic [3:0] judge(input logic [MATH_W-1:0] m,
                                       input logic [MATH_W-1:0] r,
                                       input logic [MATH_W-1:0] p);
    logic [MATH_W-1:0] ms;
    logic [MATH_W-1:0] rs;
    logic [MATH_W-1:0] d1;
    logic [MATH_W-1:0] d5;
    ms = m * MATH_W'(SCALE);
    rs = r * MATH_W'(SCALE);
    d1 = r * p;
    d5 = d1 * MATH_W'(HYST_DIV);
    judge[0] = ms > rs + d5;
    judge[1] = ms < rs - d5;
    judge[2] = ms <= rs + d5 - d1;
    judge[3] = ms >= rs - d5 + d1;
  endfunction
  logic [3:0] jv;
  logic [3:0] jf;
  // Over and under limits: dropout beyond the delta, pickup one hysteresis back inside
  assign jv = judge(MATH_W'(flags.meas_v), MATH_W'(flags.rated_v), MATH_W'(flags.v_pct));
  assign jf = judge(MATH_W'(flags.meas_f), MATH_W'(flags.rated_f), MATH_W'(flags.f_pct));
  assign flags.beyond = {jf[1:0], jv[1:0]};
  assign flags.back_in = {jf[3:2], jv[3:2]};
endmodule // limit_checker
`default_nettype wire

// file: rtl/qual_timer.sv
// Dropout qualification timers and out-of-range latches for one source
`timescale 1ns/1ps
`default_nettype none
module qual_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  src_flags_if.qual flags
);
  import src_mon_pkg::*;
  typedef struct packed {
    logic [NCOND-1:0][CNT_W-1:0] cnt;
    logic [NCOND-1:0] fault;
  } qual_s;
  qual_s st;
  qual_s next_st;
  // ----------------------------------------
  // Qualify dropout, release at pickup
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < NCOND; i++)
    begin
      if (st.fault[i])
      begin
        next_st.cnt[i] = '0;
        if (flags.back_in[i])
          next_st.fault[i] = 1'b0;
      end
      else if (!flags.beyond[i])
        next_st.cnt[i] = '0;
      else if (flags.tick)
      begin
        if (st.cnt[i] >= flags.delay)
          next_st.fault[i] = 1'b1;
        else
          next_st.cnt[i] = st.cnt[i] + CNT_W'(1);
      end
    end
  end
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end
  assign flags.fault = st.fault;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_uv_qualify;
    $rose(st.fault[C_UV]) |-> $past(flags.tick) && $past(flags.beyond[C_UV])
      && ($past(st.cnt[C_UV]) >= $past(flags.delay));
  endproperty
  a_uv_qualify: assert property (p_uv_qualify) else $error("UV fault without full delay");
  property p_restart;
    !flags.beyond[C_OF] && !st.fault[C_OF] |=> st.cnt[C_OF] == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");
  property p_pickup;
    st.fault[C_UV] && flags.back_in[C_UV] |=> !st.fault[C_UV];
  endproperty
  a_pickup: assert property (p_pickup) else $error("fault kept past pickup");
  property p_gap;
    (flags.beyond & flags.back_in) == '0;
  endproperty
  a_gap: assert property (p_gap) else $error("dropout and pickup overlap");
endmodule // qual_timer
`default_nettype wire

// file: rtl/source_threshold_monitor.sv
// Two-source supervision and transfer sequencing for the auto_transfer_unit
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Both sources are supervised; over or under voltage triggers transfer away.
// - Voltage delta dropout defaults to 10 percent, legal 4 to 20 in 2s.
// - Frequency delta dropout defaults to 5 percent, legal 2 to 10 in 1s.
// - Pickup hysteresis is fixed at one fifth of the delta dropout.
// - Voltage above over-voltage dropout is out of range; transfer starts.
// - Voltage back at over-voltage pickup allows return to normal.
// - Voltage below under-voltage dropout is out of range; transfer starts.
// - Voltage back at under-voltage pickup allows return to normal.
// - Frequency above over-frequency dropout is out of range; transfer starts.
// - Frequency back at over-frequency pickup allows return to normal.
// - Frequency below under-frequency dropout is out of range; transfer starts.
// - Frequency back at under-frequency pickup allows return to normal.
// - Under-voltage is declared only after outlasting the qualification delay.
// - Reading at or past pickup ends the out-of-range state.
// - Open transition breaks the present source before making the other.
// - Delayed transition holds contacts off for the set delay first.
// - Remote panel settings win over local panel settings.
// - Preferred source comes from a DIP switch.
// - Rated voltage comes from a DIP switch.
module source_threshold_monitor
  import src_mon_pkg::*;
#(
  parameter int TICK_CYCLES_P = src_mon_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0][src_mon_pkg::V_W-1:0] meas_v,
  input wire logic [1:0][src_mon_pkg::F_W-1:0] meas_f,
  input wire logic dip_pref_src,
  input wire logic [1:0] dip_rated_v,
  input wire logic dip_rated_f,
  input wire logic [src_mon_pkg::PCT_W-1:0] local_v_pct,
  input wire logic [src_mon_pkg::PCT_W-1:0] local_f_pct,
  input wire logic remote_link_up,
  input wire logic [src_mon_pkg::PCT_W-1:0] remote_v_pct,
  input wire logic [src_mon_pkg::PCT_W-1:0] remote_f_pct,
  input wire logic [src_mon_pkg::CNT_W-1:0] qual_delay,
  input wire logic delayed_en,
  input wire logic [src_mon_pkg::CNT_W-1:0] center_off_delay,
  output logic [1:0] contact_close,
  output logic [1:0] src_fault,
  output logic active_src,
  output logic load_supplied,
  output logic [src_mon_pkg::PCT_W-1:0] eff_v_pct,
  output logic [src_mon_pkg::PCT_W-1:0] eff_f_pct
);
  import src_mon_pkg::*;
  localparam int TCW = $clog2(TICK_CYCLES_P);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES_P - 1);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (TICK_CYCLES_P < 2)
  begin : g_bad_tick
    $error("TICK_CYCLES_P must be at least 2");
  end

  typedef struct packed {
    logic [TCW-1:0] tick_cnt;
    logic tick;
    logic [PCT_W-1:0] v_pct;
    logic [PCT_W-1:0] f_pct;
    logic [V_W-1:0] rated_v;
    logic [F_W-1:0] rated_f;
    sw_state_e state;
    logic active;
    logic [1:0] close;
    logic [CNT_W-1:0] wait_cnt;
    logic [1:0] fault;
    logic supplied;
  } top_s;
  top_s st;
  top_s next_st;
  logic [1:0] raw_fault;

  // ----------------------------------------
  // Setting legality
  // ----------------------------------------
  function automatic logic v_legal(input logic [PCT_W-1:0] p);
    v_legal = (p >= V_PCT_MIN) && (p <= V_PCT_MAX) && !p[0];
  endfunction
  function automatic logic f_legal(input logic [PCT_W-1:0] p);
    f_legal = (p >= F_PCT_MIN) && (p <= F_PCT_MAX);
  endfunction

  // ----------------------------------------
  // Per-source checker and qualifier
  // ----------------------------------------
  src_flags_if flg [2] ();
  for (genvar s = 0; s < 2; s++)
  begin : g_src
    assign flg[s].meas_v = meas_v[s];
    assign flg[s].meas_f = meas_f[s];
    assign flg[s].rated_v = st.rated_v;
    assign flg[s].rated_f = st.rated_f;
    assign flg[s].v_pct = st.v_pct;
    assign flg[s].f_pct = st.f_pct;
    assign flg[s].tick = st.tick;
    assign flg[s].delay = qual_delay;
    assign raw_fault[s] = |flg[s].fault;
    limit_checker u_chk (
      .flags(flg[s])
    );
    qual_timer u_qual (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .flags(flg[s])
    );
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic want;
  logic want_ok;
  always_comb
  begin
    next_st = st;
    // Millisecond tick for all delays
    if (st.tick_cnt == TICK_LAST)
    begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + TCW'(1);
      next_st.tick = 1'b0;
    end
    // Remote panel over local; an illegal remote value falls back to local, an illegal local value to default
    if (remote_link_up && v_legal(remote_v_pct))
      next_st.v_pct = remote_v_pct;
    else if (v_legal(local_v_pct))
      next_st.v_pct = local_v_pct;
    else
      next_st.v_pct = V_PCT_DEF;
    if (remote_link_up && f_legal(remote_f_pct))
      next_st.f_pct = remote_f_pct;
    else if (f_legal(local_f_pct))
      next_st.f_pct = local_f_pct;
    else
      next_st.f_pct = F_PCT_DEF;
    // Rated values from DIP switches
    unique case (dip_rated_v)
      2'h0: next_st.rated_v = RATED_V0;
      2'h1: next_st.rated_v = RATED_V1;
      2'h2: next_st.rated_v = RATED_V2;
      2'h3: next_st.rated_v = RATED_V3;
    endcase
    next_st.rated_f = dip_rated_f ? RATED_F60 : RATED_F50;
    next_st.fault = raw_fault;
    // Preferred source first, else the other if it is healthy
    want = st.fault[dip_pref_src] ? !dip_pref_src : dip_pref_src;
    want_ok = !st.fault[want];
    // Contact sequencing
    unique case (st.state)
      ST_CLOSED:
      begin
        if (want_ok && (want != st.active))
        begin
          next_st.state = ST_OPEN;
          next_st.close = 2'h0;
          next_st.wait_cnt = '0;
          next_st.supplied = 1'b0;
        end
      end
      ST_OPEN:
      begin
        if (delayed_en && (st.wait_cnt < center_off_delay))
        begin
          if (st.tick)
            next_st.wait_cnt = st.wait_cnt + CNT_W'(1);
        end
        else if (want_ok)
        begin
          next_st.state = ST_CLOSED;
          next_st.active = want;
          next_st.close = want ? 2'h2 : 2'h1;
          next_st.supplied = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.state <= ST_OPEN;
      st.v_pct <= V_PCT_DEF;
      st.f_pct <= F_PCT_DEF;
      st.rated_v <= RATED_V0;
      st.rated_f <= RATED_F50;
    end
    else
      st <= next_st;
  end

  // Outputs straight from state flops
  assign contact_close = st.close;
  assign src_fault = st.fault;
  assign active_src = st.active;
  assign load_supplied = st.supplied;
  assign eff_v_pct = st.v_pct;
  assign eff_f_pct = st.f_pct;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_break_make;
    ($rose(st.close[0]) || $rose(st.close[1])) |-> $past(st.close) == 2'h0;
  endproperty
  a_break_make: assert property (p_break_make) else $error("make before break");

  property p_delay_hold;
    ($rose(st.close[0]) || $rose(st.close[1])) && $past(delayed_en)
      |-> $past(st.wait_cnt) >= $past(center_off_delay);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("center-off cut short");

  property p_leave_fault;
    st.state == ST_CLOSED && st.fault[st.active] && !st.fault[!st.active]
      |=> st.state == ST_OPEN && st.close == 2'h0;
  endproperty
  a_leave_fault: assert property (p_leave_fault) else $error("no transfer on fault");

  property p_pref;
    st.state == ST_CLOSED && !st.fault[dip_pref_src] && st.active != dip_pref_src
      |=> st.state == ST_OPEN;
  endproperty
  a_pref: assert property (p_pref) else $error("no return to preferred");

  property p_remote;
    remote_link_up && v_legal(remote_v_pct) |=> st.v_pct == $past(remote_v_pct);
  endproperty
  a_remote: assert property (p_remote) else $error("remote setting ignored");

  property p_v_range;
    v_legal(st.v_pct);
  endproperty
  a_v_range: assert property (p_v_range) else $error("voltage delta illegal");

  property p_f_range;
    f_legal(st.f_pct);
  endproperty
  a_f_range: assert property (p_f_range) else $error("frequency delta illegal");

  property p_rated;
    dip_rated_v == 2'h3 |=> st.rated_v == RATED_V3;
  endproperty
  a_rated: assert property (p_rated) else $error("rated voltage not taken");

  property p_single_close;
    st.close != 2'h3;
  endproperty
  a_single_close: assert property (p_single_close) else $error("both sources closed");

  property p_dead_load;
    st.close == 2'h0 |-> !st.supplied;
  endproperty
  a_dead_load: assert property (p_dead_load) else $error("load supplied while open");

  property p_hold_off;
    st.state == ST_OPEN && delayed_en && (st.wait_cnt < center_off_delay)
      |=> st.close == 2'h0;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("closed during center-off");

  property p_remote_f;
    remote_link_up && f_legal(remote_f_pct) |=> st.f_pct == $past(remote_f_pct);
  endproperty
  a_remote_f: assert property (p_remote_f) else $error("remote frequency ignored");

  property p_local_v;
    !remote_link_up && v_legal(local_v_pct) |=> st.v_pct == $past(local_v_pct);
  endproperty
  a_local_v: assert property (p_local_v) else $error("local voltage setting ignored");

  property p_fault_reg;
    st.fault == $past(raw_fault);
  endproperty
  a_fault_reg: assert property (p_fault_reg) else $error("source fault not registered");

  c_transfer: cover property (st.state == ST_CLOSED && st.fault[st.active] ##1
    st.state == ST_OPEN);
  c_delayed: cover property (delayed_en && st.state == ST_OPEN && st.wait_cnt != '0);
  c_return: cover property (st.active != dip_pref_src ##1 st.active == dip_pref_src);
  c_fault: cover property ($rose(st.fault[0]));
  c_remote: cover property (remote_link_up && st.v_pct == remote_v_pct);
endmodule // source_threshold_monitor
`default_nettype wire

// file: verif/src_sense_model.sv
// Behavioural voltage and frequency sensing of the two supply sources
`timescale 1ns/1ps
`default_nettype none
module src_sense_model (
  input wire logic ref_clk,
  output logic [1:0][src_mon_pkg::V_W-1:0] meas_v,
  output logic [1:0][src_mon_pkg::F_W-1:0] meas_f
);
  import src_mon_pkg::*;
  // ----------------------------------------
  // Readings
  // ----------------------------------------
  // Both sources start healthy at 400 V, 50 Hz
  initial
  begin
    meas_v = {2{10'h190}};
    meas_f = {2{13'h1388}};
  end
  // New reading lands just after an edge, like a sensor update
  task automatic set_src(input int s, input logic [V_W-1:0] v, input logic [F_W-1:0] f);
    @(posedge ref_clk);
    #1;
    meas_v[s] = v;
    meas_f[s] = f;
  endtask
endmodule // src_sense_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the source threshold monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import src_mon_pkg::*;
  localparam int TCK = 4;
  // Center-off time of 500 ticks; a tick here is TCK clocks, not 1 ms
  localparam int COD = 500;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0][V_W-1:0] meas_v;
  logic [1:0][F_W-1:0] meas_f;
  logic dip_pref_src = 1'b0;
  logic [1:0] dip_rated_v = 2'h3;
  logic dip_rated_f = 1'b0;
  logic [PCT_W-1:0] local_v_pct = 5'h0A;
  logic [PCT_W-1:0] local_f_pct = 5'h05;
  logic remote_link_up = 1'b0;
  logic [PCT_W-1:0] remote_v_pct = 5'h0A;
  logic [PCT_W-1:0] remote_f_pct = 5'h05;
  logic [CNT_W-1:0] qual_delay = 16'h0002;
  logic delayed_en = 1'b0;
  logic [CNT_W-1:0] center_off_delay = 16'h0000;
  logic [1:0] contact_close;
  logic [1:0] src_fault;
  logic active_src;
  logic load_supplied;
  logic [PCT_W-1:0] eff_v_pct;
  logic [PCT_W-1:0] eff_f_pct;
  logic [V_W-1:0] vn = 10'h190;
  int error_cnt = 0;
  int samples_checked = 0;
  // ----------------------------------------
  // Clock, partner and design
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;
  src_sense_model sense_i (.ref_clk(ref_clk), .meas_v(meas_v), .meas_f(meas_f));
  source_threshold_monitor #(.TICK_CYCLES_P(TCK)) source_threshold_monitor_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .meas_v(meas_v), .meas_f(meas_f),
    .dip_pref_src(dip_pref_src), .dip_rated_v(dip_rated_v), .dip_rated_f(dip_rated_f),
    .local_v_pct(local_v_pct), .local_f_pct(local_f_pct), .remote_link_up(remote_link_up),
    .remote_v_pct(remote_v_pct), .remote_f_pct(remote_f_pct), .qual_delay(qual_delay),
    .delayed_en(delayed_en), .center_off_delay(center_off_delay),
    .contact_close(contact_close), .src_fault(src_fault), .active_src(active_src),
    .load_supplied(load_supplied), .eff_v_pct(eff_v_pct), .eff_f_pct(eff_f_pct));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cycle(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_flt(input int s, input logic e);
    int n;
    n = 0;
    while (src_fault[s] !== e && n < 80)
    begin
      cycle(1);
      n++;
    end
    chk({15'h0000, src_fault[s]}, {15'h0000, e});
  endtask
  task automatic wait_cc(input logic [1:0] e);
    int n;
    n = 0;
    while (contact_close !== e && n < 2100)
    begin
      cycle(1);
      n++;
    end
    chk({14'h0000, contact_close}, {14'h0000, e});
  endtask
  // One reading changed on a source, the other kept nominal
  task automatic put(input int s, input logic isf, input logic [12:0] val);
    if (isf)
      sense_i.set_src(s, vn, val);
    else
      sense_i.set_src(s, val[9:0], 13'h1388);
  endtask
  // Edge of dropout, beyond it, inside hysteresis, at pickup
  task automatic cond(input logic isf, input logic [12:0] a, input logic [12:0] b,
                      input logic [12:0] c, input logic [12:0] d);
    put(1, isf, a);
    cycle(40);
    chk({15'h0000, src_fault[1]}, 16'h0000);
    put(1, isf, b);
    cycle(6);
    chk({15'h0000, src_fault[1]}, 16'h0000);
    wait_flt(1, 1'b1);
    put(1, isf, c);
    cycle(40);
    chk({15'h0000, src_fault[1]}, 16'h0001);
    put(1, isf, d);
    wait_flt(1, 1'b0);
    $display("test cond %h/%h finished", a, d);
  endtask
  // Fault on the active source, transfer out and back
  task automatic xfer(input logic dly);
    int n;
    delayed_en = dly;
    center_off_delay = 16'h01F4;
    put(0, 1'b0, 13'h01B9);
    wait_flt(0, 1'b1);
    wait_cc(2'b00);
    chk({15'h0000, load_supplied}, 16'h0000);
    n = 0;
    while (contact_close === 2'b00 && n < 2100)
    begin
      cycle(1);
      n++;
    end
    chk({14'h0000, contact_close}, 16'h0002);
    chk({15'h0000, active_src}, 16'h0001);
    if (dly)
      chk({15'h0000, n >= (COD - 1) * TCK + 2 && n <= COD * TCK + 1}, 16'h0001);
    else
      chk({15'h0000, n == 1}, 16'h0001);
    put(0, 1'b0, 13'h0190);
    wait_flt(0, 1'b0);
    wait_cc(2'b01);
    $display("test transfer delayed=%0d finished", dly);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    #(20000 * 50);
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cycle(3);
    chk({11'h000, eff_v_pct}, 16'h000A);
    chk({11'h000, eff_f_pct}, 16'h0005);
    chk({14'h0000, contact_close}, 16'h0000);
    reset_n = 1'b1;
    wait_cc(2'b01);
    dip_pref_src = 1'b1;
    wait_cc(2'b10);
    dip_pref_src = 1'b0;
    wait_cc(2'b01);
    remote_link_up = 1'b1;
    remote_v_pct = 5'h08;
    remote_f_pct = 5'h03;
    cycle(3);
    chk({11'h000, eff_v_pct}, 16'h0008);
    chk({11'h000, eff_f_pct}, 16'h0003);
    remote_v_pct = 5'h07;
    local_v_pct = 5'h0E;
    cycle(3);
    chk({11'h000, eff_v_pct}, 16'h000E);
    remote_link_up = 1'b0;
    local_v_pct = 5'h16;
    cycle(3);
    chk({11'h000, eff_v_pct}, 16'h000A);
    chk({11'h000, eff_f_pct}, 16'h0005);
    local_v_pct = 5'h0A;
    $display("test settings finished");
    cond(1'b0, 13'h01B8, 13'h01B9, 13'h01B1, 13'h01B0);
    cond(1'b0, 13'h0168, 13'h0167, 13'h016F, 13'h0170);
    cond(1'b1, 13'h1482, 13'h1483, 13'h1451, 13'h1450);
    cond(1'b1, 13'h128E, 13'h128D, 13'h12BF, 13'h12C0);
    // Short dips restart the qualification count each time
    repeat (5)
    begin
      put(1, 1'b0, 13'h0167);
      cycle(5);
      put(1, 1'b0, 13'h0190);
    end
    cycle(20);
    chk({15'h0000, src_fault[1]}, 16'h0000);
    $display("test restart finished");
    local_v_pct = 5'h14;
    cond(1'b0, 13'h01E0, 13'h01E1, 13'h01D1, 13'h01D0);
    // Back to nominal before the delta narrows again
    put(1, 1'b0, 13'h0190);
    local_v_pct = 5'h0A;
    xfer(1'b0);
    xfer(1'b1);
    dip_rated_v = 2'h0;
    vn = 10'h0DC;
    put(0, 1'b0, 13'h00DC);
    put(1, 1'b0, 13'h00DC);
    cycle(40);
    wait_flt(0, 1'b0);
    wait_flt(1, 1'b0);
    cond(1'b0, 13'h00F2, 13'h00F3, 13'h00EE, 13'h00ED);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
